//--- hw/mpr_top.sv
// power-up response of the fieldbus master: host release, io access, slave outputs
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mpr_top #(
    parameter int NSLV = 4,
    parameter int W = 8,
    parameter int unsigned PWRUP_CYC = mpr_pkg::PWRUP_DELAY_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [1:0] SEL_POS,
    input wire logic [1:0] CFG_REPORT_MODE,
    input wire logic [NSLV-1:0] CFG_REPORT_MASK,
    input wire logic HOST_CPU_RUN,
    input wire logic [NSLV-1:0] SLAVE_READY,
    input wire logic [NSLV*W-1:0] SLAVE_IN,
    output logic [NSLV*W-1:0] SLAVE_OUT,
    output logic HOST_START_OK,
    output logic POWERFAIL_REPORT,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    mpr_pkg::mpr_state_t state_r;
    mpr_pkg::mpr_state_t state_nxt;
    logic [1:0] sel_r;
    logic [1:0] sel_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic [NSLV-1:0] mask_r;
    logic [NSLV-1:0] mask_nxt;
    logic start_r;
    logic start_nxt;
    logic pf_r;
    logic pf_nxt;
    logic [NSLV*W-1:0] in_img_r;
    logic [NSLV*W-1:0] in_nxt;
    logic [NSLV*W-1:0] out_img_r;
    logic [NSLV*W-1:0] out_nxt;
    logic [NSLV*W-1:0] so_r;
    logic [NSLV*W-1:0] so_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;
    logic deny_r;
    logic deny_nxt;
    logic [31:0] rdval;
    logic [31:0] st_word;
    logic all_ready;
    logic pf_ok;
    logic cfg_rpt;
    logic io_ok;
    logic stop_pf;
    logic req;
    logic rd_acc;
    logic wr_acc;
    logic [3:0] idx;
    logic in_hit;
    logic out_hit;

    mpr_tmr_if tmr_if ();

    mpr_tmr #(
        .LIMIT(PWRUP_CYC)
    ) u_tmr (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .t(tmr_if.tmr)
    );

    assign all_ready = &SLAVE_READY;
    // slaves outside the mask never hold the indication
    assign pf_ok = &(SLAVE_READY | ~mask_r);
    assign cfg_rpt = (CFG_REPORT_MODE == mpr_pkg::ACK_TIMEOUT_REPORT) ||
                     (CFG_REPORT_MODE == mpr_pkg::EXPANSION_POWERFAIL_REPORT);
    assign io_ok = (state_r == mpr_pkg::MPR_RUN);
    assign stop_pf = (state_r == mpr_pkg::MPR_STOP) && (mode_r == mpr_pkg::EXPANSION_POWERFAIL_REPORT);
    assign tmr_if.start = (state_r == mpr_pkg::MPR_WAIT);

    // ------------------------------------------------------------
    // power-up sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        sel_nxt = sel_r;
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        case (state_r)
            // straps caught on the first clock after release
            mpr_pkg::MPR_CAP: begin
                sel_nxt = SEL_POS;
                mode_nxt = CFG_REPORT_MODE;
                mask_nxt = CFG_REPORT_MASK;
                if (SEL_POS == mpr_pkg::RUN_SELECTOR_POSITION) begin
                    state_nxt = cfg_rpt ? mpr_pkg::MPR_WAIT : mpr_pkg::MPR_RUN;
                end else if (SEL_POS == mpr_pkg::STOP_SELECTOR_POSITION) begin
                    state_nxt = mpr_pkg::MPR_STOP;
                end else begin
                    state_nxt = mpr_pkg::MPR_OFF;
                end
            end
            mpr_pkg::MPR_WAIT: begin
                if (all_ready || tmr_if.expired) begin
                    state_nxt = mpr_pkg::MPR_RUN;
                end
            end
            default: begin
                state_nxt = state_r;
            end
        endcase
        start_nxt = (state_nxt == mpr_pkg::MPR_OFF) || (state_nxt == mpr_pkg::MPR_STOP) ||
                    (state_nxt == mpr_pkg::MPR_RUN);
        // powerfail held until masked slaves ready
        pf_nxt = (mode_r == mpr_pkg::EXPANSION_POWERFAIL_REPORT) && !pf_ok &&
                 (state_r != mpr_pkg::MPR_CAP) && (state_r != mpr_pkg::MPR_OFF);
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= mpr_pkg::MPR_CAP;
            sel_r <= mpr_pkg::OFF_POSITION;
            mode_r <= mpr_pkg::MODE_NONE;
            mask_r <= '0;
            start_r <= 1'b0;
            pf_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sel_r <= sel_nxt;
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
            start_r <= start_nxt;
            pf_r <= pf_nxt;
        end
    end

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    assign req = AVS_READ || AVS_WRITE;
    assign rd_acc = AVS_READ && ack_r;
    assign wr_acc = AVS_WRITE && ack_r;
    assign idx = AVS_ADDRESS[5:2];
    assign in_hit = (AVS_ADDRESS[7:6] == mpr_pkg::IN_WIN) && (int'(idx) < NSLV);
    assign out_hit = (AVS_ADDRESS[7:6] == mpr_pkg::OUT_WIN) && (int'(idx) < NSLV);

    always_comb begin
        st_word = '0;
        st_word[mpr_pkg::ST_START_BIT] = start_r;
        st_word[mpr_pkg::ST_PF_BIT] = pf_r;
        st_word[mpr_pkg::ST_CLEAR_BIT] = io_ok && !HOST_CPU_RUN;
        st_word[mpr_pkg::ST_IO_BIT] = io_ok;
        st_word[mpr_pkg::ST_DENY_BIT] = deny_r;
        st_word[mpr_pkg::ST_TMR_BIT] = tmr_if.expired;
        st_word[mpr_pkg::ST_SEL_LSB +: 2] = sel_r;
        st_word[mpr_pkg::ST_MODE_LSB +: 2] = mode_r;
        rdval = '0;
        if (AVS_ADDRESS == mpr_pkg::STATUS_OFS) begin
            rdval = st_word;
        end else if (AVS_ADDRESS == mpr_pkg::SLV_DIAG_OFS) begin
            if (sel_r == mpr_pkg::RUN_SELECTOR_POSITION) begin
                rdval = 32'(SLAVE_READY);
            end
        end else if (in_hit && io_ok) begin
            // inputs read as zero until released
            rdval = 32'(in_img_r[int'(idx)*W +: W]);
        end else if (out_hit && io_ok) begin
            rdval = 32'(out_img_r[int'(idx)*W +: W]);
        end
    end

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, registered read data
    // ------------------------------------------------------------
    always_comb begin
        ack_nxt = req && !ack_r;
        rd_nxt = (AVS_READ && !ack_r) ? rdval : rd_r;
        deny_nxt = deny_r;
        if (wr_acc && (AVS_ADDRESS == mpr_pkg::STATUS_OFS) && AVS_BYTEENABLE[0] &&
            AVS_WRITEDATA[mpr_pkg::ST_DENY_BIT]) begin
            deny_nxt = 1'b0;
        end
        // denied access flagged except in stop with powerfail reporting, set beats clear
        if ((rd_acc || wr_acc) && (in_hit || out_hit) && !io_ok && !stop_pf) begin
            deny_nxt = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r <= 1'b0;
            rd_r <= mpr_pkg::RDATA_RST;
            deny_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
            deny_r <= deny_nxt;
        end
    end

    assign AVS_WAITREQUEST = req && !ack_r;
    assign AVS_READDATA = rd_r;

    // ------------------------------------------------------------
    // input image, output image, slave outputs
    // ------------------------------------------------------------
    always_comb begin
        in_nxt = io_ok ? SLAVE_IN : in_img_r;
        out_nxt = out_img_r;
        if (wr_acc && out_hit && io_ok) begin
            for (int b = 0; b < W; b++) begin
                if (AVS_BYTEENABLE[b / 8]) begin
                    out_nxt[int'(idx)*W + b] = AVS_WRITEDATA[b];
                end
            end
        end
        case (state_r)
            mpr_pkg::MPR_RUN: begin
                so_nxt = HOST_CPU_RUN ? out_img_r : '0;
            end
            mpr_pkg::MPR_WAIT: begin
                so_nxt = HOST_CPU_RUN ? so_r : '0;
            end
            default: begin
                so_nxt = so_r;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            in_img_r <= '0;
            out_img_r <= '0;
            so_r <= '0;
        end else begin
            in_img_r <= in_nxt;
            out_img_r <= out_nxt;
            so_r <= so_nxt;
        end
    end

    assign SLAVE_OUT = so_r;
    assign HOST_START_OK = start_r;
    assign POWERFAIL_REPORT = pf_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence rd_done(logic hit);
        AVS_READ && !AVS_WAITREQUEST && hit;
    endsequence

    sequence wr_done(logic hit);
        AVS_WRITE && !AVS_WAITREQUEST && hit;
    endsequence

    off_release_a: assert property ((state_r == mpr_pkg::MPR_OFF) |-> HOST_START_OK && !io_ok)
        else $error("off position must release host and deny io");
    deny_flag_a: assert property (wr_done(out_hit) and (state_r == mpr_pkg::MPR_STOP) && !stop_pf
                                  |=> deny_r)
        else $error("denied io access not flagged");
    zero_inputs_a: assert property (rd_done(in_hit) and (state_r != mpr_pkg::MPR_RUN)
                                    |-> AVS_READDATA == 32'h0000_0000)
        else $error("input image visible before release");
    refuse_write_a: assert property (wr_done(out_hit) and (state_r != mpr_pkg::MPR_RUN)
                                     |=> $stable(out_img_r))
        else $error("output write taken before release");
    pf_hold_a: assert property ((mode_r == mpr_pkg::EXPANSION_POWERFAIL_REPORT) && !pf_ok &&
                                (state_r == mpr_pkg::MPR_STOP || state_r == mpr_pkg::MPR_RUN)
                                |=> POWERFAIL_REPORT)
        else $error("powerfail dropped early");
    host_hold_a: assert property ((state_r == mpr_pkg::MPR_WAIT) && !all_ready && !tmr_if.expired
                                  |=> !HOST_START_OK)
        else $error("host released before slaves or delay");
    image_load_a: assert property ((state_r == mpr_pkg::MPR_RUN) |=> in_img_r == $past(SLAVE_IN))
        else $error("input image not loaded from slaves");
    // release edge still sits in cap, so the sampled reset gates the attempt
    quick_run_a: assert property (RESET_N && (state_r == mpr_pkg::MPR_CAP) && !cfg_rpt &&
                                  (SEL_POS == mpr_pkg::RUN_SELECTOR_POSITION)
                                  |=> (state_r == mpr_pkg::MPR_RUN) && HOST_START_OK)
        else $error("run without reporting must start at once");
    clear_out_a: assert property ((state_r == mpr_pkg::MPR_RUN || state_r == mpr_pkg::MPR_WAIT) &&
                                  !HOST_CPU_RUN |=> SLAVE_OUT == '0)
        else $error("outputs not zero with host stopped");
    keep_out_a: assert property ((state_r == mpr_pkg::MPR_OFF || state_r == mpr_pkg::MPR_STOP)
                                 |=> $stable(SLAVE_OUT))
        else $error("outputs changed in off or stop");
    slv_diag_a: assert property (rd_done(AVS_ADDRESS == mpr_pkg::SLV_DIAG_OFS) and
                                 (sel_r != mpr_pkg::RUN_SELECTOR_POSITION)
                                 |-> AVS_READDATA == 32'h0000_0000)
        else $error("slave diagnostics readable outside run");
endmodule : mpr_top
`default_nettype wire

//--- include/mpr_pkg.sv
// shared constants and types for the master power-up response block
package mpr_pkg;
    // ------------------------------------------------------------
    // selector positions and error-reporting modes
    // ------------------------------------------------------------
    localparam logic [1:0] OFF_POSITION = 2'h0;
    localparam logic [1:0] STOP_SELECTOR_POSITION = 2'h1;
    localparam logic [1:0] RUN_SELECTOR_POSITION = 2'h2;
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] ACK_TIMEOUT_REPORT = 2'h1;
    localparam logic [1:0] EXPANSION_POWERFAIL_REPORT = 2'h2;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] SLV_DIAG_OFS = 8'h04;
    localparam logic [1:0] IN_WIN = 2'h1;
    localparam logic [1:0] OUT_WIN = 2'h2;
    localparam int ST_START_BIT = 0;
    localparam int ST_PF_BIT = 1;
    localparam int ST_CLEAR_BIT = 2;
    localparam int ST_IO_BIT = 3;
    localparam int ST_DENY_BIT = 4;
    localparam int ST_TMR_BIT = 5;
    localparam int ST_SEL_LSB = 8;
    localparam int ST_MODE_LSB = 12;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int PWRUP_DELAY_MS = 100;
    localparam int PWRUP_DELAY_CYC = PWRUP_DELAY_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {MPR_CAP, MPR_OFF, MPR_STOP, MPR_WAIT, MPR_RUN} mpr_state_t;
endpackage : mpr_pkg

//--- include/mpr_tmr_if.sv
// power-up delay timer hookup between control and timer
`timescale 1ns/1ps
`default_nettype none
interface mpr_tmr_if;
    logic start;
    logic expired;
    modport ctl (output start, input expired);
    modport tmr (input start, output expired);
endinterface : mpr_tmr_if
`default_nettype wire

//--- hw/mpr_tmr.sv
// power-up delay timer, level expiry while start is held
`timescale 1ns/1ps
`default_nettype none
module mpr_tmr #(
    parameter int unsigned LIMIT = 2000000
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    mpr_tmr_if.tmr t
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic exp_r;
    logic exp_nxt;

    // ------------------------------------------------------------
    // count while started, drop back when start falls
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt = '0;
        exp_nxt = 1'b0;
        if (t.start) begin
            exp_nxt = exp_r || (cnt_r == LAST);
            cnt_nxt = exp_nxt ? cnt_r : cnt_r + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign t.expired = exp_r;
endmodule : mpr_tmr
`default_nettype wire

//--- tb/mpr_slv_model.sv
// behavioural model of the remote slave stations on the fieldbus
`timescale 1ns/1ps
`default_nettype none
module mpr_slv_model #(
    parameter int NSLV = 4,
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NSLV-1:0] ready_req,
    input wire logic [W-1:0] in_base,
    input wire logic [NSLV*W-1:0] slave_out,
    output logic [NSLV-1:0] slave_ready,
    output logic [NSLV*W-1:0] slave_in
);
    // ------------------------------------------------------------
    // station state
    // ------------------------------------------------------------
    logic [NSLV*W-1:0] data_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_ready <= '0;
            data_r <= '0;
        end else begin
            slave_ready <= ready_req;
            for (int i = 0; i < NSLV; i++) begin
                // unreachable station: lines toggle so stale data never looks valid
                data_r[i*W +: W] <= ready_req[i] ? in_base + W'(i) : ~data_r[i*W +: W];
            end
        end
    end
    assign slave_in = data_r;
endmodule : mpr_slv_model
`default_nettype wire

//--- tb/master_powerup_response_tb.sv
// self-checking bench for the master power-up response block
`timescale 1ns/1ps
`default_nettype none
module master_powerup_response_tb;
    localparam int NSLV = 4;
    localparam int W = 8;
    // short power-up delay keeps the run brief
    localparam int PCYC = 20;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] sel_pos = 2'h0;
    logic [1:0] mode = 2'h0;
    logic [NSLV-1:0] mask = '0;
    logic host_run = 1'b0;
    logic [NSLV-1:0] ready_req = '0;
    logic [W-1:0] in_base = 8'h30;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [NSLV-1:0] slave_ready;
    logic [NSLV*W-1:0] slave_in;
    logic [NSLV*W-1:0] slave_out;
    logic start_ok;
    logic pf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] q;
    int fail_count = 0;
    int comparisons = 0;

    always #25 core_clk = ~core_clk;

    mpr_top #(.NSLV(NSLV), .W(W), .PWRUP_CYC(PCYC)) u_dut (
        .CORE_CLK(core_clk), .RESET_N(reset_n), .SEL_POS(sel_pos), .CFG_REPORT_MODE(mode),
        .CFG_REPORT_MASK(mask), .HOST_CPU_RUN(host_run), .SLAVE_READY(slave_ready), .SLAVE_IN(slave_in),
        .SLAVE_OUT(slave_out), .HOST_START_OK(start_ok), .POWERFAIL_REPORT(pf), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

    mpr_slv_model #(.NSLV(NSLV), .W(W)) u_slv (
        .clk(core_clk), .rst_n(reset_n), .ready_req(ready_req), .in_base(in_base),
        .slave_out(slave_out), .slave_ready(slave_ready), .slave_in(slave_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(32'(n < 20), 32'h1);
    endtask : bus

    task automatic pu(input logic [1:0] s, input logic [1:0] m, input logic [3:0] k, input logic h,
                      input logic [3:0] r);
        @(posedge core_clk);
        reset_n <= 1'b0;
        sel_pos <= s;
        mode <= m;
        mask <= k;
        host_run <= h;
        ready_req <= r;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : pu

    task automatic wait_start(input int lim);
        int n;
        n = 0;
        while (start_ok !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(start_ok), 32'h1);
    endtask : wait_start

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        // off position: released at once, io denied, outputs kept
        pu(mpr_pkg::OFF_POSITION, mpr_pkg::EXPANSION_POWERFAIL_REPORT, 4'h1, 1'b1, 4'hf);
        chk(32'(start_ok), 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h80, 32'ha5);
        repeat (3) @(posedge core_clk);
        chk(slave_out, '0);
        bus(1'b0, mpr_pkg::STATUS_OFS, 32'h0);
        chk(32'(q[mpr_pkg::ST_DENY_BIT]), 32'h1);
        bus(1'b1, mpr_pkg::STATUS_OFS, 32'h10);
        bus(1'b0, mpr_pkg::STATUS_OFS, 32'h0);
        chk(32'(q[mpr_pkg::ST_DENY_BIT]), 32'h0);
        bus(1'b0, mpr_pkg::SLV_DIAG_OFS, 32'h0);
        chk(q, 32'h0);
        // stop with no reporting and with timeout reporting
        for (int m = 0; m < 2; m++) begin
            pu(mpr_pkg::STOP_SELECTOR_POSITION, 2'(m), 4'h3, 1'b1, 4'hf);
            chk(32'(start_ok), 32'h1);
            bus(1'b0, 8'h44, 32'h0);
            chk(q, 32'h0);
            bus(1'b1, 8'h84, 32'h3c);
            bus(1'b0, mpr_pkg::STATUS_OFS, 32'h0);
            chk(32'(q[mpr_pkg::ST_DENY_BIT]), 32'h1);
            bus(1'b0, mpr_pkg::SLV_DIAG_OFS, 32'h0);
            chk(q, 32'h0);
        end
        // stop with powerfail: one masked station late
        pu(mpr_pkg::STOP_SELECTOR_POSITION, mpr_pkg::EXPANSION_POWERFAIL_REPORT, 4'h2, 1'b1, 4'h1);
        chk(32'(start_ok), 32'h1);
        chk(32'(pf), 32'h1);
        bus(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h80, 32'h5a);
        repeat (3) @(posedge core_clk);
        chk(slave_out, '0);
        chk(32'(pf), 32'h1);
        ready_req <= 4'h3;
        repeat (3) @(posedge core_clk);
        chk(32'(pf), 32'h0);
        // run with timeout reporting: waits for every station
        pu(mpr_pkg::RUN_SELECTOR_POSITION, mpr_pkg::ACK_TIMEOUT_REPORT, 4'h1, 1'b1, 4'h0);
        ready_req <= 4'h7;
        repeat (6) @(posedge core_clk);
        chk(32'(start_ok), 32'h0);
        chk(slave_out, '0);
        ready_req <= 4'hf;
        wait_start(6);
        for (int i = 0; i < NSLV; i++) begin
            bus(1'b0, 8'(8'h40 + 4 * i), 32'h0);
            chk(q, 32'(in_base + 8'(i)));
        end
        bus(1'b1, 8'h84, 32'h5a);
        repeat (3) @(posedge core_clk);
        chk(32'(slave_out[15:8]), 32'h5a);
        // no lane enabled: the output image must keep its byte
        avs_byteenable <= 4'h0;
        bus(1'b1, 8'h84, 32'h11);
        avs_byteenable <= 4'hf;
        bus(1'b0, 8'h84, 32'h0);
        chk(q, 32'h5a);
        bus(1'b0, mpr_pkg::SLV_DIAG_OFS, 32'h0);
        chk(q, 32'hf);
        // run with powerfail, host stopped, delay expiry
        pu(mpr_pkg::RUN_SELECTOR_POSITION, mpr_pkg::EXPANSION_POWERFAIL_REPORT, 4'h4, 1'b0, 4'h0);
        repeat (9) @(posedge core_clk);
        chk(32'(start_ok), 32'h0);
        chk(32'(pf), 32'h1);
        wait_start(15);
        bus(1'b1, 8'h80, 32'hff);
        repeat (3) @(posedge core_clk);
        chk(slave_out, '0);
        bus(1'b0, mpr_pkg::STATUS_OFS, 32'h0);
        chk(32'(q[mpr_pkg::ST_CLEAR_BIT]), 32'h1);
        chk(q, 32'h0000_220f);
        ready_req <= 4'hf;
        repeat (3) @(posedge core_clk);
        bus(1'b0, 8'h48, 32'h0);
        chk(q, 32'(in_base + 8'h2));
        chk(32'(pf), 32'h0);
        // run without reporting: no wait at all
        pu(mpr_pkg::RUN_SELECTOR_POSITION, mpr_pkg::MODE_NONE, 4'h0, 1'b1, 4'h0);
        chk(32'(start_ok), 32'h1);
        in_base <= 8'h70;
        ready_req <= 4'hf;
        repeat (3) @(posedge core_clk);
        bus(1'b0, 8'h4c, 32'h0);
        chk(q, 32'h73);
        end_of_test();
    end
endmodule : master_powerup_response_tb
`default_nettype wire
